// ===== icap_pkg.sv
// shared constants and types for the image capture block
package icap_pkg;
   localparam int PIX_W = 16;
   localparam logic [7:0] RUN_OFF = 8'h00;
   localparam logic [7:0] CFG_OFF = 8'h04;
   localparam logic [7:0] ADDR_OFF = 8'h08;
   localparam logic [7:0] STAT_OFF = 8'h0C;
   localparam logic [7:0] ACT_ADDR_OFF = 8'h10;
   localparam int RUN_EN_BIT = 0;
   localparam int CFG_BYPASS_BIT = 0;
   localparam int CFG_SWAP_BIT = 1;
   localparam int ST_FRAME_BIT = 0;
   localparam int ST_EN_BIT = 1;
   localparam int ST_OVF_BIT = 2;
   localparam int ST_SWAP_BIT = 3;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam int BUF_DEPTH = 2;
   typedef struct packed {
      logic sof;
      logic sol;
      logic phase;
      logic [PIX_W-1:0] data;
   } icap_pix_type;
endpackage : icap_pkg

// ===== icap_capture.sv
// image capture controller: apb registers, shadowing, pixel feed to preview
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - with shadow bypass set, memory output address writes take effect at once, even mid-frame
// - with shadow bypass clear, shadowed registers load at the next frame start
// - capture enable and luma/chroma swap always load at frame start
// - memory output address is immediate only when shadow bypass is set
// - pixels on an asynchronous pixel clock reach preview without pattern shift
module icap_capture (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pix_clk,
   input wire logic pix_vsync,
   input wire logic pix_hsync,
   input wire logic [icap_pkg::PIX_W-1:0] pix_data,
   output icap_pkg::icap_pix_type prev_word,
   output logic prev_valid,
   input wire logic prev_ready,
   output logic [31:0] mem_out_addr
);
   ////////////////////////////////////////////////////////////////////////
   // input synchronisers: first stage feeds only the second
   logic [2:0] pclk_sync_reg;
   logic [1:0] vs_sync_reg, hs_sync_reg;
   logic [icap_pkg::PIX_W-1:0] dat_s1_reg, dat_s2_reg;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pclk_sync_reg <= 3'h0;
         vs_sync_reg <= 2'h0;
         hs_sync_reg <= 2'h0;
         dat_s1_reg <= '0;
         dat_s2_reg <= '0;
      end else begin
         pclk_sync_reg <= {pclk_sync_reg[1:0], pix_clk};
         vs_sync_reg <= {vs_sync_reg[0], pix_vsync};
         hs_sync_reg <= {hs_sync_reg[0], pix_hsync};
         dat_s1_reg <= pix_data;
         dat_s2_reg <= dat_s1_reg;
      end
   end
   // data and clock share the same sync depth, so the sampled word matches its edge
   logic pix_edge, frame_start, line_start;
   logic vs_last_reg, hs_last_reg;
   assign pix_edge = pclk_sync_reg[1] & ~pclk_sync_reg[2];
   // strobes edge-detected on the system clock: a stopped pixel clock still closes lines and frames
   assign frame_start = vs_sync_reg[1] & ~vs_last_reg;
   assign line_start = hs_sync_reg[1] & ~hs_last_reg;

   ////////////////////////////////////////////////////////////////////////
   // registers, apb slave, shadow logic
   logic en_wr_reg, en_wr_next, en_act_reg, en_act_next;
   logic swap_wr_reg, swap_wr_next, swap_act_reg, swap_act_next;
   logic bypass_reg, bypass_next, ovf_reg, ovf_next, busy_reg, busy_next;
   logic [31:0] addr_wr_reg, addr_wr_next, addr_act_reg, addr_act_next;
   logic [31:0] prdata_next;
   logic pready_next, pslverr_next, wr_acc, ovf_set, mapped;
   logic [7:0] off;
   assign off = paddr[7:0];
   assign mapped = (paddr[31:8] == 24'h0) && (off == icap_pkg::RUN_OFF || off == icap_pkg::CFG_OFF ||
      off == icap_pkg::ADDR_OFF || off == icap_pkg::STAT_OFF || off == icap_pkg::ACT_ADDR_OFF);
   assign wr_acc = psel & penable & pready & pwrite & mapped;
   always_comb begin
      en_wr_next = en_wr_reg;
      swap_wr_next = swap_wr_reg;
      bypass_next = bypass_reg;
      addr_wr_next = addr_wr_reg;
      en_act_next = en_act_reg;
      swap_act_next = swap_act_reg;
      addr_act_next = addr_act_reg;
      busy_next = busy_reg;
      ovf_next = ovf_reg;
      pready_next = psel & penable & ~pready;
      pslverr_next = psel & penable & ~pready & ~mapped;
      prdata_next = prdata;
      if (psel & ~penable) begin
         case (off)
            icap_pkg::RUN_OFF: prdata_next = {31'h0, en_wr_reg};
            icap_pkg::CFG_OFF: prdata_next = {30'h0, swap_wr_reg, bypass_reg};
            icap_pkg::ADDR_OFF: prdata_next = addr_wr_reg;
            icap_pkg::STAT_OFF: prdata_next = {28'h0, swap_act_reg, ovf_reg, en_act_reg, busy_reg};
            icap_pkg::ACT_ADDR_OFF: prdata_next = addr_act_reg;
            default: prdata_next = 32'h0000_0000;
         endcase
      end
      if (wr_acc) begin
         case (off)
            icap_pkg::RUN_OFF: en_wr_next = pwdata[icap_pkg::RUN_EN_BIT];
            icap_pkg::CFG_OFF: begin
               bypass_next = pwdata[icap_pkg::CFG_BYPASS_BIT];
               swap_wr_next = pwdata[icap_pkg::CFG_SWAP_BIT];
            end
            icap_pkg::ADDR_OFF: begin
               addr_wr_next = pwdata;
               if (bypass_reg) addr_act_next = pwdata;
            end
            icap_pkg::STAT_OFF: if (pwdata[icap_pkg::ST_OVF_BIT]) ovf_next = 1'b0;
            default: ;
         endcase
      end
      if (frame_start) begin
         en_act_next = en_wr_reg;
         swap_act_next = swap_wr_reg;
         if (!bypass_reg) addr_act_next = addr_wr_reg;
         busy_next = en_wr_reg;
      end else if (!vs_sync_reg[1]) begin
         busy_next = 1'b0;
      end
      if (ovf_set) ovf_next = 1'b1;
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         en_wr_reg <= 1'b0;
         en_act_reg <= 1'b0;
         swap_wr_reg <= 1'b0;
         swap_act_reg <= 1'b0;
         bypass_reg <= 1'b0;
         ovf_reg <= 1'b0;
         busy_reg <= 1'b0;
         addr_wr_reg <= icap_pkg::ADDR_RST;
         addr_act_reg <= icap_pkg::ADDR_RST;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         en_wr_reg <= en_wr_next;
         en_act_reg <= en_act_next;
         swap_wr_reg <= swap_wr_next;
         swap_act_reg <= swap_act_next;
         bypass_reg <= bypass_next;
         ovf_reg <= ovf_next;
         busy_reg <= busy_next;
         addr_wr_reg <= addr_wr_next;
         addr_act_reg <= addr_act_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
      end
   end
   assign mem_out_addr = addr_act_reg;

   ////////////////////////////////////////////////////////////////////////
   // pixel capture and two-entry buffer toward preview
   logic phase_reg, phase_next, sof_pend_reg, sof_pend_next, sol_pend_reg, sol_pend_next;
   logic vs_last_next, hs_last_next, push, pop, prev_valid_next;
   icap_pkg::icap_pix_type word, buf_reg [icap_pkg::BUF_DEPTH], buf_next [icap_pkg::BUF_DEPTH];
   logic [1:0] cnt_reg, cnt_next;
   logic en_now, swap_now;
   // a frame start in the same cycle as a pixel already uses the newly loaded settings
   assign en_now = frame_start ? en_wr_reg : en_act_reg;
   assign swap_now = frame_start ? swap_wr_reg : swap_act_reg;
   assign push = pix_edge & en_now & vs_sync_reg[1] & hs_sync_reg[1];
   assign pop = prev_valid & prev_ready;
   assign ovf_set = push & (cnt_reg == 2'd2) & ~pop;
   always_comb begin
      word.sof = sof_pend_reg | frame_start;
      word.sol = sol_pend_reg | line_start;
      word.phase = (frame_start | line_start) ? 1'b0 : phase_reg;
      word.data = swap_now ? {dat_s2_reg[7:0], dat_s2_reg[15:8]} : dat_s2_reg;
      vs_last_next = vs_sync_reg[1];
      hs_last_next = hs_sync_reg[1];
      phase_next = phase_reg;
      sof_pend_next = sof_pend_reg | frame_start;
      sol_pend_next = sol_pend_reg | line_start;
      if (frame_start | line_start) phase_next = 1'b0;
      if (push) begin
         phase_next = ~word.phase;
         sof_pend_next = 1'b0;
         sol_pend_next = 1'b0;
      end
      buf_next = buf_reg;
      cnt_next = cnt_reg;
      if (pop) begin
         buf_next[0] = buf_reg[1];
         cnt_next = cnt_reg - 2'd1;
      end
      if (push && cnt_next != 2'd2) begin
         buf_next[cnt_next[0]] = word;
         cnt_next = cnt_next + 2'd1;
      end
      prev_valid_next = cnt_next != 2'd0;
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         vs_last_reg <= 1'b0;
         hs_last_reg <= 1'b0;
         phase_reg <= 1'b0;
         sof_pend_reg <= 1'b0;
         sol_pend_reg <= 1'b0;
         cnt_reg <= 2'd0;
         prev_valid <= 1'b0;
         buf_reg[0] <= '0;
         buf_reg[1] <= '0;
      end else begin
         vs_last_reg <= vs_last_next;
         hs_last_reg <= hs_last_next;
         phase_reg <= phase_next;
         sof_pend_reg <= sof_pend_next;
         sol_pend_reg <= sol_pend_next;
         cnt_reg <= cnt_next;
         prev_valid <= prev_valid_next;
         buf_reg <= buf_next;
      end
   end
   assign prev_word = buf_reg[0];

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence addr_write_s;
      wr_acc && off == icap_pkg::ADDR_OFF;
   endsequence
   bypass_addr_a: assert property (addr_write_s and bypass_reg |=> addr_act_reg == $past(pwdata))
      else $error("immediate address write not applied");
   hold_addr_a: assert property (!bypass_reg && !frame_start |=> $stable(addr_act_reg))
      else $error("shadowed address changed outside frame start");
   enable_shadow_a: assert property (!frame_start |=> $stable(en_act_reg))
      else $error("enable changed outside frame start");
   swap_shadow_a: assert property (!frame_start |=> $stable(swap_act_reg))
      else $error("swap changed outside frame start");
   addr_load_a: assert property (frame_start && !bypass_reg && !(wr_acc && off == icap_pkg::ADDR_OFF)
      |=> addr_act_reg == $past(addr_wr_reg))
      else $error("address not loaded at frame start");
   phase_reset_a: assert property (frame_start && !push |=> phase_reg == 1'b0)
      else $error("phase not realigned at frame start");
   push_store_a: assert property (push && cnt_reg != 2'd2 && !pop |=> cnt_reg == $past(cnt_reg) + 2'd1)
      else $error("captured pixel not buffered");
   first_word_a: assert property (push && cnt_reg == 2'd0 |=> prev_valid && prev_word.data == $past(word.data))
      else $error("pixel data shifted on the way to preview");
   apb_ready_a: assert property (psel && !penable ##1 psel && penable |=> pready)
      else $error("apb answer late");
endmodule : icap_capture

// ===== icap_pix_src.sv
// pixel source model: gated pixel clock with frame and line strobes
`timescale 1ns/10ps
module icap_pix_src (
   output logic pix_clk,
   output logic pix_vsync,
   output logic pix_hsync,
   output logic [15:0] pix_data
);
   initial begin
      pix_clk = 1'h0;
      pix_vsync = 1'h0;
      pix_hsync = 1'h0;
      pix_data = 16'h0;
   end
   ////////////////////////////////////////
   // clock stands still between frames; data moves on the falling edge
   task automatic frame(input int l, input int p, input logic [15:0] b);
      pix_vsync = 1'h1;
      for (int y = 0; y < l; y++) begin
         #80 pix_hsync = 1'h1;
         for (int x = 0; x < p; x++) begin
            pix_data = b + 16'(y * 16 + x);
            #40 pix_clk = 1'h1;
            #40 pix_clk = 1'h0;
         end
         pix_hsync = 1'h0;
         // no stale value left on the bus between lines
         pix_data = ~pix_data;
      end
      // clock stays stopped after the frame; the receiver must close it on vsync alone
      #80 pix_vsync = 1'h0;
   endtask : frame
endmodule : icap_pix_src

// ===== icap_capture_tb_top.sv
// self-checking bench for the image capture block
`timescale 1ns/10ps
module icap_capture_tb_top;
   logic clock = 1'h0;
   logic reset_n = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, prev_ready = 1'h0, hold = 1'h0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv, mem_out_addr;
   logic pready, pslverr, errv, prev_valid, pix_clk, pix_vsync, pix_hsync;
   logic [1:0] cyc = 2'h0;
   logic [15:0] pix_data;
   icap_pkg::icap_pix_type prev_word;
   icap_pkg::icap_pix_type got_q[$];
   int error_cnt = 0, n_compared = 0;
   always #5 clock = ~clock;
   // preview side stalls two clocks in four unless held off
   always @(posedge clock) begin
      cyc <= cyc + 2'h1;
      prev_ready <= !hold && cyc[1];
      if (prev_valid === 1'h1 && prev_ready === 1'h1) begin
         got_q.push_back(prev_word);
      end
   end
   icap_capture i_icap_capture (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pix_clk(pix_clk), .pix_vsync(pix_vsync), .pix_hsync(pix_hsync), .pix_data(pix_data),
      .prev_word(prev_word), .prev_valid(prev_valid), .prev_ready(prev_ready), .mem_out_addr(mem_out_addr));
   icap_pix_src i_icap_pix_src (.pix_clk(pix_clk), .pix_vsync(pix_vsync), .pix_hsync(pix_hsync),
      .pix_data(pix_data));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 50);
      rdv = prdata;
      errv = pslverr;
      chk(32'(n < 50), 32'h1);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
   endtask : apb
   task automatic st(input int b, input logic e);
      apb(1'h0, icap_pkg::STAT_OFF, 32'h0);
      chk(32'(rdv[b]), 32'(e));
   endtask : st
   // sync latency is a few clocks, so a fixed settle follows each frame
   task automatic fr(input int l, input int p, input logic [15:0] b);
      i_icap_pix_src.frame(l, p, b);
      repeat (8) @(posedge clock);
   endtask : fr
   task automatic chk_frame(input int l, input int p, input logic [15:0] b, input logic sw);
      logic [15:0] v;
      chk(32'(got_q.size()), 32'(l * p));
      foreach (got_q[i]) begin
         v = b + 16'((i / p) * 16 + i % p);
         if (sw) v = {v[7:0], v[15:8]};
         chk(32'(got_q[i]), 32'({i == 0, i % p == 0, 1'(i % p), v}));
      end
      got_q.delete();
   endtask : chk_frame
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   ////////////////////////////////////////
   initial begin
      #100us;
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clock);
      reset_n <= 1'h1;
      @(posedge clock);
      apb(1'h0, icap_pkg::CFG_OFF, 32'h0);
      chk(rdv, 32'h0);
      st(icap_pkg::ST_EN_BIT, 1'h0);
      apb(1'h0, 8'h20, 32'h0);
      chk({rdv[31:1], errv}, 32'h1);
      $display("test reset and map done");
      apb(1'h1, icap_pkg::ADDR_OFF, 32'h1000);
      chk(mem_out_addr, icap_pkg::ADDR_RST);
      apb(1'h1, icap_pkg::RUN_OFF, 32'h1);
      st(icap_pkg::ST_EN_BIT, 1'h0);
      fr(2, 3, 16'h1200);
      chk(mem_out_addr, 32'h1000);
      st(icap_pkg::ST_EN_BIT, 1'h1);
      chk_frame(2, 3, 16'h1200, 1'h0);
      $display("test shadowed load done");
      apb(1'h1, icap_pkg::CFG_OFF, 32'h3);
      st(icap_pkg::ST_SWAP_BIT, 1'h0);
      fork
         fr(1, 3, 16'hA55A);
         begin
            repeat (12) @(posedge clock);
            st(icap_pkg::ST_FRAME_BIT, 1'h1);
            apb(1'h1, icap_pkg::ADDR_OFF, 32'h3000);
            chk(mem_out_addr, 32'h3000);
         end
      join
      chk_frame(1, 3, 16'hA55A, 1'h1);
      st(icap_pkg::ST_FRAME_BIT, 1'h0);
      apb(1'h0, icap_pkg::ACT_ADDR_OFF, 32'h0);
      chk(rdv, 32'h3000);
      $display("test bypass and swap done");
      hold <= 1'h1;
      fr(1, 4, 16'h0100);
      st(icap_pkg::ST_OVF_BIT, 1'h1);
      hold <= 1'h0;
      repeat (8) @(posedge clock);
      chk_frame(1, 2, 16'h0100, 1'h1);
      apb(1'h1, icap_pkg::STAT_OFF, 32'h4);
      st(icap_pkg::ST_OVF_BIT, 1'h0);
      $display("test buffer overflow done");
      apb(1'h1, icap_pkg::RUN_OFF, 32'h0);
      fr(1, 2, 16'h0700);
      st(icap_pkg::ST_EN_BIT, 1'h0);
      chk(32'(got_q.size()), 32'h0);
      apb(1'h1, icap_pkg::CFG_OFF, 32'h0);
      apb(1'h1, icap_pkg::RUN_OFF, 32'h1);
      fr(1, 2, 16'h0800);
      chk_frame(1, 2, 16'h0800, 1'h0);
      $display("test disable and reprogram done");
      finish_test();
   end
endmodule : icap_capture_tb_top
